/* inc/ftep_regs.vh */
// opcodes, register layout and reset values for the training/ecc/protect block
`ifndef FTEP_REGS_VH
`define FTEP_REGS_VH

`define FTEP_OP_READ_PATTERN    8'h41
`define FTEP_OP_PROGRAM_PATTERN 8'h43
`define FTEP_OP_WRITE_VPATTERN  8'h4a
`define FTEP_OP_READ_ECC        8'hb3
`define FTEP_OP_WRITE_ECC       8'hb5
`define FTEP_OP_CLEAR_ECC       8'hb6
`define FTEP_OP_WRITE_ENABLE    8'h06
`define FTEP_OP_WRITE_STATUS    8'h01
`define FTEP_OP_PAGE_PROGRAM    8'h02
`define FTEP_OP_SECTOR_ERASE    8'h20

`define FTEP_ECC_DISABLE_BIT    0
`define FTEP_ECC_EVENT_BIT      1
`define FTEP_ECC_COUNT_LSB      2
`define FTEP_ECC_COUNT_MSB      5
`define FTEP_ECC_REPROG_BIT     6
`define FTEP_ECC_COUNT_MAX      4'hf

`define FTEP_PATTERN_NV_RESET   8'h00
`define FTEP_ECC_RESET          8'h00

`define FTEP_ST_QE_BIT          6
`define FTEP_ST_STATUS_WRITE_DISABLE_BIT        7
`define FTEP_ST_BP_LSB          2
`define FTEP_ST_BP_MSB          5
`define FTEP_ST_WEL_BIT         1
`define FTEP_ST_RESET           8'h00

`endif

/* tb/flash_training_ecc_protect_regs_tb.sv */
// self-checking bench for the training/ecc/protect block
`timescale 1ns/100ps
`default_nettype none
module flash_training_ecc_protect_regs_tb;
  reg        clk, srst, wp_n, correction_pulse, reprogram_hit, bp_region_hit;
  reg        persistent_protect_bit, dynamic_protect_bit, training_phase;
  wire       sck, cs_n, si, so_out, so_oe_n, array_program, array_erase, correction_disable;
  wire [7:0] status_reg;
  integer    num_errors, checked, cyc, np, ne, k;
  ftep_core i_ftep_core (.clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n), .si(si),
    .so_out(so_out), .so_oe_n(so_oe_n), .wp_n(wp_n), .correction_pulse(correction_pulse),
    .reprogram_hit(reprogram_hit), .bp_region_hit(bp_region_hit),
    .persistent_protect_bit(persistent_protect_bit), .dynamic_protect_bit(dynamic_protect_bit),
    .training_phase(training_phase), .array_program(array_program), .array_erase(array_erase),
    .correction_disable(correction_disable), .status_reg(status_reg));
  ftep_host i_ftep_host (.clk(clk), .so_out(so_out), .so_oe_n(so_oe_n), .sck(sck),
    .cs_n(cs_n), .si(si));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (array_program === 1'b1) np = np + 1;
    if (array_erase === 1'b1) ne = ne + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      report_and_stop;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rd(input [7:0] op, input [7:0] exp);
    begin
      i_ftep_host.frame(op, 8'h00, 1'b1);
      chk(i_ftep_host.rx, exp);
    end
  endtask
  // write enable in its own frame, then the write
  task wr(input [7:0] op, input [7:0] d);
    begin
      i_ftep_host.frame(8'h06, 8'h00, 1'b0);
      i_ftep_host.frame(op, d, 1'b1);
    end
  endtask
  task rst;
    begin
      srst = 1'b1;
      repeat (3) @(negedge clk);
      srst = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask
  task report_and_stop;
    begin
      $display("num_errors=%0d checked=%0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0; wp_n = 1'b1; correction_pulse = 1'b0; reprogram_hit = 1'b0;
    bp_region_hit = 1'b0; persistent_protect_bit = 1'b1; dynamic_protect_bit = 1'b1;
    training_phase = 1'b0;
    num_errors = 0; checked = 0; cyc = 0; np = 0; ne = 0;
    rst;
    rd(8'h41, 8'h00);
    rd(8'hb3, 8'h00);
    i_ftep_host.frame(8'h4a, 8'ha5, 1'b1);
    rd(8'h41, 8'h00);
    wr(8'h4a, 8'ha5);
    rd(8'h41, 8'ha5);
    training_phase = 1'b1;
    i_ftep_host.frame(8'h00, 8'h00, 1'b0);
    chk(i_ftep_host.rx, 8'ha5);
    training_phase = 1'b0;
    wr(8'h43, 8'h3c);
    rst;
    rd(8'h41, 8'h3c);
    wr(8'hb5, 8'hff);
    chk({7'h00, correction_disable}, 8'h01);
    rd(8'hb3, 8'h01);
    wr(8'hb5, 8'h00);
    repeat (17) begin
      @(negedge clk) correction_pulse = 1'b1;
      @(negedge clk) correction_pulse = 1'b0;
    end
    rd(8'hb3, 8'h3e);
    reprogram_hit = 1'b1;
    wr(8'h02, 8'h5a);
    rd(8'hb3, 8'h7e);
    reprogram_hit = 1'b0;
    wr(8'hb5, 8'h01);
    i_ftep_host.frame(8'hb6, 8'h00, 1'b0);
    rd(8'hb3, 8'h01);
    wr(8'h01, 8'h80);
    wp_n = 1'b0;
    wr(8'h01, 8'h3c);
    chk(status_reg & 8'hfc, 8'h80);
    wp_n = 1'b1;
    wr(8'h01, 8'h3c);
    chk(status_reg & 8'hfc, 8'h3c);
    for (k = 0; k < 4; k = k + 1) begin // unprotected on the first pass, then one protection scheme per pass
      bp_region_hit = (k == 1);
      persistent_protect_bit = (k != 2);
      dynamic_protect_bit = (k != 3);
      wr(8'h02, 8'h11);
      wr(8'h20, 8'h00);
    end
    chk(np[7:0], 8'h01);
    chk(ne[7:0], 8'h01);
    report_and_stop;
  end
endmodule // flash_training_ecc_protect_regs_tb
`default_nettype wire

/* tb/ftep_core_sva.sv */
// assertion checker for the training/ecc/protect block
`timescale 1ns/100ps
`default_nettype none
module ftep_core_sva (
  // watched ports
  input wire logic       clk, srst, cs_n, wp_n, reprogram_hit, bp_region_hit,
  input wire logic       persistent_protect_bit, dynamic_protect_bit, so_oe_n,
  input wire logic       array_program, array_erase, correction_disable,
  input wire logic [7:0] status_reg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  chk_reset_idle: assert property ($fell(srst) |-> so_oe_n && !correction_disable)
    else $error("outputs not idle after reset");
  chk_prog_pulse: assert property (array_program |=> !array_program)
    else $error("program pulse too long");
  chk_erase_pulse: assert property (array_erase |=> !array_erase)
    else $error("erase pulse too long");
  chk_prog_guard: assert property (array_program |-> persistent_protect_bit &&
    dynamic_protect_bit && !(bp_region_hit && |status_reg[5:2]))
    else $error("program in protected region");
  chk_erase_guard: assert property (array_erase |-> persistent_protect_bit &&
    dynamic_protect_bit && !(bp_region_hit && |status_reg[5:2]))
    else $error("erase in protected region");
  chk_reprog_drop: assert property (array_program |-> !reprogram_hit || correction_disable)
    else $error("reprogram with correction on");
  chk_status_lock: assert property (!wp_n [*4] ##0 status_reg[7] |=> $stable(status_reg[7:2]))
    else $error("locked status bits changed");
  chk_disable_commit: assert property ($changed(correction_disable) |-> cs_n)
    else $error("disable bit changed inside frame");
  chk_release_idle: assert property (cs_n [*4] |-> so_oe_n)
    else $error("output driven while deselected");
endmodule // ftep_core_sva
bind ftep_core ftep_core_sva i_ftep_core_sva (.clk(clk), .srst(srst), .cs_n(cs_n), .wp_n(wp_n),
  .reprogram_hit(reprogram_hit), .bp_region_hit(bp_region_hit), .so_oe_n(so_oe_n),
  .persistent_protect_bit(persistent_protect_bit), .dynamic_protect_bit(dynamic_protect_bit),
  .array_program(array_program), .array_erase(array_erase),
  .correction_disable(correction_disable), .status_reg(status_reg));
`default_nettype wire

/* tb/ftep_host.sv */
// serial host model driving command frames
`timescale 1ns/100ps
`default_nettype none
module ftep_host (
  // pins
  input  wire clk, so_out, so_oe_n,
  output reg  sck, cs_n, si
);
  reg [7:0] rx;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    rx = 8'h00;
  end
  // one frame, msb first, mode 0; rx keeps last byte seen
  task frame(input [7:0] op, input [7:0] dat, input has_dat);
    integer i;
    reg [15:0] sh;
    begin
      sh = {op, dat};
      cs_n = 1'b0;
      for (i = 0; i < (has_dat ? 16 : 8); i = i + 1) begin
        si = sh[15-i];
        repeat (4) @(negedge clk);
        sck = 1'b1;
        rx = {rx[6:0], so_oe_n ? ~so_out : so_out};
        repeat (4) @(negedge clk);
        sck = 1'b0;
      end
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      si = ~si;
      repeat (12) @(negedge clk);
    end
  endtask
endmodule // ftep_host
`default_nettype wire

/* verilog/ftep_core.v */
// serial command decoder with training pattern, ecc register and write protection
`timescale 1ns/100ps
`default_nettype none
`include "ftep_regs.vh"

// How it works
// - two 8-bit pattern stores, nonvolatile one ships as zero
// - reset copies nonvolatile pattern into the volatile store
// - host may rewrite volatile pattern once write-enable latch is set; reset restores nonvolatile value
// - dummy-cycle training pattern is driven from the volatile store
// - opcodes 41h read, 43h program nonvolatile, 4ah write volatile pattern
// - opcodes b3h read, b5h write, b6h clear the ecc register
// - ecc bit 0 disables correction when one, resets to zero
// - ecc bit 1 read-only flag set on any correction
// - ecc bits 5:2 count corrections, saturate at 15
// - reprogram inside ecc boundary ignored when ecc on, flagged in bit 6
// - ecc bit 7 reserved reads zero; whole register zero after reset
// - status protect bits locked only when write-disable set and wp pin low
// - program, erase, register writes need write-enable latch set first
// - region protected if block-protect or sector protection protects it
// - any block-protect bit set enables block protection
// - refuse program or erase while either per-region protect bit is zero
module ftep_core (
  // clock and reset
  input  wire       clk,
  input  wire       srst,
  // serial link pins
  input  wire       sck,
  input  wire       cs_n,
  input  wire       si,
  output reg        so_out,
  output reg        so_oe_n,
  input  wire       wp_n,
  // array side events
  input  wire       correction_pulse,
  input  wire       reprogram_hit,
  input  wire       bp_region_hit,
  input  wire       persistent_protect_bit,
  input  wire       dynamic_protect_bit,
  input  wire       training_phase,
  // array commands
  output reg        array_program,
  output reg        array_erase,
  output reg        correction_disable,
  output reg  [7:0] status_reg
);

  // synchronisers
  reg [2:0] sck_s;
  reg [1:0] cs_s;
  reg [1:0] si_s;
  reg [1:0] wp_s;
  always @(posedge clk) begin
    sck_s <= {sck_s[1:0], sck};
    cs_s  <= {cs_s[0], cs_n};
    si_s  <= {si_s[0], si};
    wp_s  <= {wp_s[0], wp_n};
  end
  wire sck_rise = sck_s[1] & ~sck_s[2];
  wire sck_fall = ~sck_s[1] & sck_s[2];
  wire cs_act   = ~cs_s[1];

  // frame states
  localparam [2:0] ST_IDLE  = 3'b000;
  localparam [2:0] ST_OPC   = 3'b001;
  localparam [2:0] ST_DATA  = 3'b010;
  localparam [2:0] ST_FULL  = 3'b011;
  localparam [2:0] ST_SEND  = 3'b100;
  localparam [2:0] ST_TRAIN = 3'b101;

  // frame state and shifters
  reg [2:0] frame_st;
  reg [2:0] next_frame_st;
  reg [7:0] shift_in;
  reg [7:0] opcode;
  reg [7:0] shift_out;
  reg [3:0] bit_cnt;
  reg [2:0] train_cnt;

  // register storage
  reg [7:0] pattern_store_nonvolatile;
  reg [7:0] pattern_store_volatile;
  reg [7:0] ecc_reg;
  reg       write_enable_latch;
  reg       nv_loaded;

  // next values
  reg [7:0] next_ecc;
  reg [3:0] next_count;
  reg [7:0] next_status;

  // protection
  wire status_locked = status_reg[`FTEP_ST_STATUS_WRITE_DISABLE_BIT] & ~wp_s[1];
  wire bp_enabled    = |status_reg[`FTEP_ST_BP_MSB:`FTEP_ST_BP_LSB];
  wire sector_prot   = ~persistent_protect_bit | ~dynamic_protect_bit;
  wire region_prot   = (bp_enabled & bp_region_hit) | sector_prot;
  wire reprog_block  = ~ecc_reg[`FTEP_ECC_DISABLE_BIT] & reprogram_hit;

  // bit and byte strobes
  wire [7:0] next_shift = {shift_in[6:0], si_s[1]};
  wire       in_frame   = (frame_st == ST_OPC) | (frame_st == ST_DATA) |
                          (frame_st == ST_FULL);
  wire       take_bit   = cs_act & sck_rise & in_frame;
  wire       byte_done  = take_bit & (bit_cnt == 4'h7);
  wire       op_done    = byte_done & (frame_st == ST_OPC);
  wire       data_done  = byte_done & (frame_st != ST_OPC);
  // one-cycle strobe: the frame state leaves full on the next edge
  wire       commit     = ~cs_act & (frame_st == ST_FULL) & write_enable_latch;
  wire       train_go   = (next_frame_st == ST_TRAIN) & (frame_st != ST_TRAIN);

  // opcode decode
  wire op_write_enable_cmd    = op_done & (next_shift == `FTEP_OP_WRITE_ENABLE);
  wire op_rd_pat  = op_done & (next_shift == `FTEP_OP_READ_PATTERN);
  wire op_rd_ecc  = op_done & (next_shift == `FTEP_OP_READ_ECC);
  wire op_clr_ecc = op_done & (next_shift == `FTEP_OP_CLEAR_ECC);
  wire op_read    = op_rd_pat | op_rd_ecc;
  wire wr_nv_pat  = commit & (opcode == `FTEP_OP_PROGRAM_PATTERN);
  wire wr_v_pat   = commit & (opcode == `FTEP_OP_WRITE_VPATTERN);
  wire wr_ecc     = commit & (opcode == `FTEP_OP_WRITE_ECC);
  wire wr_status  = commit & (opcode == `FTEP_OP_WRITE_STATUS);
  wire wr_prog    = commit & (opcode == `FTEP_OP_PAGE_PROGRAM);
  wire wr_erase   = commit & (opcode == `FTEP_OP_SECTOR_ERASE);
  wire wr_any     = wr_nv_pat | wr_v_pat | wr_ecc | wr_status | wr_prog | wr_erase;

  // next frame state
  always @* begin
    next_frame_st = frame_st;
    case (frame_st)
      ST_IDLE: begin
        if (cs_act && training_phase) begin
          next_frame_st = ST_TRAIN;
        end else if (cs_act) begin
          next_frame_st = ST_OPC;
        end
      end
      ST_OPC: begin
        if (training_phase) begin
          next_frame_st = ST_TRAIN;
        end else if (op_read) begin
          next_frame_st = ST_SEND;
        end else if (op_done) begin
          next_frame_st = ST_DATA;
        end
      end
      ST_DATA: begin
        if (data_done) begin
          next_frame_st = ST_FULL;
        end
      end
      ST_FULL: begin
        next_frame_st = ST_FULL;
      end
      ST_SEND: begin
        next_frame_st = ST_SEND;
      end
      ST_TRAIN: begin
        next_frame_st = ST_TRAIN;
      end
      default: begin
        next_frame_st = ST_IDLE;
      end
    endcase
    // deselect ends any frame, cut or whole
    if (!cs_act) begin
      next_frame_st = ST_IDLE;
    end
  end

  // serial framer, msb first; later data bytes overwrite earlier ones
  always @(posedge clk) begin
    if (srst) begin
      frame_st <= ST_IDLE;
      shift_in <= 8'h00;
      opcode   <= 8'h00;
      bit_cnt  <= 4'h0;
    end else begin
      frame_st <= next_frame_st;
      if (!cs_act) begin
        bit_cnt <= 4'h0;
      end else if (take_bit) begin
        shift_in <= next_shift;
        if (byte_done) begin
          bit_cnt <= 4'h0;
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
        end
        if (op_done) begin
          opcode <= next_shift;
        end
      end
    end
  end

  // serial output: read data or training pattern
  always @(posedge clk) begin
    if (srst) begin
      shift_out <= 8'h00;
      train_cnt <= 3'h0;
      so_out    <= 1'b0;
      so_oe_n   <= 1'b1;
    end else if (!cs_act) begin
      train_cnt <= 3'h0;
      so_oe_n   <= 1'b1;
    end else if (train_go) begin
      // first bit before the first rising edge, so the host sees all eight
      so_out    <= pattern_store_volatile[7];
      so_oe_n   <= 1'b0;
      train_cnt <= 3'h1;
    end else if (frame_st == ST_TRAIN) begin
      if (sck_fall) begin
        so_out    <= pattern_store_volatile[3'h7 - train_cnt];
        train_cnt <= train_cnt + 3'h1;
      end
    end else if (op_rd_pat) begin
      shift_out <= pattern_store_volatile;
    end else if (op_rd_ecc) begin
      shift_out <= {1'b0, ecc_reg[6:0]};
    end else if (frame_st == ST_SEND) begin
      if (sck_fall) begin
        so_out    <= shift_out[7];
        so_oe_n   <= 1'b0;
        shift_out <= {shift_out[6:0], shift_out[7]};
      end
    end
  end

  // volatile pattern, reloaded from the nonvolatile copy after reset
  always @(posedge clk) begin
    if (srst) begin
      pattern_store_volatile <= `FTEP_PATTERN_NV_RESET;
      nv_loaded              <= 1'b0;
    end else if (!nv_loaded) begin
      pattern_store_volatile <= pattern_store_nonvolatile;
      nv_loaded              <= 1'b1;
    end else if (wr_v_pat) begin
      pattern_store_volatile <= shift_in;
    end
  end

  // nonvolatile pattern keeps its value through reset
  always @(posedge clk) begin
    if (wr_nv_pat) begin
      pattern_store_nonvolatile <= shift_in;
    end
  end

  initial pattern_store_nonvolatile = `FTEP_PATTERN_NV_RESET;

  // write enable latch, cleared by every accepted write
  always @(posedge clk) begin
    if (srst) begin
      write_enable_latch <= 1'b0;
    end else if (op_write_enable_cmd) begin
      write_enable_latch <= 1'b1;
    end else if (wr_any) begin
      write_enable_latch <= 1'b0;
    end
  end

  // status register next value
  always @* begin
    next_status = status_reg;
    if (wr_status && !status_locked) begin
      next_status = {shift_in[7:2], 1'b1, status_reg[0]};
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      status_reg <= `FTEP_ST_RESET;
    end else begin
      status_reg <= next_status;
    end
  end

  // correction counter; a correction in the clear cycle still counts
  always @* begin
    next_count = ecc_reg[`FTEP_ECC_COUNT_MSB:`FTEP_ECC_COUNT_LSB];
    if (op_clr_ecc) begin
      next_count = 4'h0;
    end
    if (correction_pulse && !ecc_reg[`FTEP_ECC_DISABLE_BIT]) begin
      if (next_count != `FTEP_ECC_COUNT_MAX) begin
        next_count = next_count + 4'h1;
      end
    end
  end

  // ecc register next value; set events win over a clear
  always @* begin
    next_ecc = ecc_reg;
    if (wr_ecc) begin
      next_ecc[`FTEP_ECC_DISABLE_BIT] = shift_in[0];
    end
    if (op_clr_ecc) begin
      next_ecc[6:1] = 6'h00;
    end
    if (correction_pulse && !ecc_reg[`FTEP_ECC_DISABLE_BIT]) begin
      next_ecc[`FTEP_ECC_EVENT_BIT] = 1'b1;
    end
    if (wr_prog && reprog_block) begin
      next_ecc[`FTEP_ECC_REPROG_BIT] = 1'b1;
    end
    next_ecc[`FTEP_ECC_COUNT_MSB:`FTEP_ECC_COUNT_LSB] = next_count;
    next_ecc[7] = 1'b0;
  end

  // ecc register and its disable output
  always @(posedge clk) begin
    if (srst) begin
      ecc_reg            <= `FTEP_ECC_RESET;
      correction_disable <= 1'b0;
    end else begin
      ecc_reg            <= next_ecc;
      correction_disable <= next_ecc[`FTEP_ECC_DISABLE_BIT];
    end
  end

  // array command pulses, one cycle after the commit
  always @(posedge clk) begin
    if (srst) begin
      array_program <= 1'b0;
      array_erase   <= 1'b0;
    end else begin
      array_program <= 1'b0;
      array_erase   <= 1'b0;
      if (wr_prog && !reprog_block && !region_prot) begin
        array_program <= 1'b1;
      end
      if (wr_erase && !region_prot) begin
        array_erase <= 1'b1;
      end
    end
  end

endmodule // ftep_core
`default_nettype wire
